// [design/rcp_pkg.sv]
// shared constants, types and lookup for the register control path
package rcp_pkg;

	// ************************************************************
	// widths
	// ************************************************************
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int REGISTER_SELECT_CODE_W = 5;
	localparam int UNIT_W = 3;
	localparam int JMP_W  = 13;
	localparam int CNT_W  = 4;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS      = 25;
	localparam int MSYN_SETUP_NS      = 150;
	localparam int STROBE_DELAY_NS    = 85;
	localparam int STROBE_LEN_NS      = 135;
	localparam int DEMAND_SETTLE_NS   = 220;
	localparam int READ_SSYN_DELAY_NS = 220;
	localparam int ADDR_HOLD_NS       = 75;
	localparam logic [CNT_W-1:0] MSYN_SETUP_CYC =
		CNT_W'((MSYN_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] STROBE_DELAY_CYC =
		CNT_W'((STROBE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] STROBE_LEN_CYC =
		CNT_W'((STROBE_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] DEMAND_SETTLE_CYC =
		CNT_W'((DEMAND_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] READ_SSYN_CYC =
		CNT_W'((READ_SSYN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] ADDR_HOLD_CYC =
		CNT_W'((ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ************************************************************
	// address map and local register layout
	// ************************************************************
	localparam logic             BIG_MAP      = 1'b0;
	localparam logic [REGISTER_SELECT_CODE_W-1:0] LOC_WC_IDX   = 5'h00;
	localparam logic [REGISTER_SELECT_CODE_W-1:0] LOC_CS2_IDX  = 5'h01;
	localparam logic [REGISTER_SELECT_CODE_W-1:0] LOC_STAT_IDX = 5'h02;
	localparam int CS2_UNIT_LSB  = 0;
	localparam int CS2_CLR_BIT   = 5;
	localparam int STAT_PERR_BIT = 0;
	localparam int STAT_CNT_LSB  = 8;
	localparam logic [DATA_W-1:0] WC_RST   = 16'h0000;
	localparam logic [UNIT_W-1:0] UNIT_RST = 3'h0;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		RCP_DATI  = 2'h0,
		RCP_DATIP = 2'h1,
		RCP_DATO  = 2'h2,
		RCP_DATOB = 2'h3
	} rcp_cyc_t;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'h0,
		ST_CLAIM   = 3'h1,
		ST_STROBE  = 3'h3,
		ST_SSYN    = 3'h2,
		ST_SETTLE  = 3'h6,
		ST_DEMAND  = 3'h7,
		ST_RDLY    = 3'h5,
		ST_RELEASE = 3'h4
	} rcp_state_t;

	typedef struct packed {
		logic              local_remote_flag;
		logic              decoder_code_bit_b;
		logic              decoder_code_bit_a;
		logic [REGISTER_SELECT_CODE_W-1:0] register_select_code;
	} rcp_sel_t;

	// word index to register select; anything not local goes to the drive
	function automatic rcp_sel_t rcp_lookup(input logic [REGISTER_SELECT_CODE_W-1:0] idx);
		rcp_sel_t s;
		s = '{1'b0, 1'b0, 1'b0, idx};
		if (idx == LOC_WC_IDX)
			s = '{1'b1, 1'b0, 1'b0, idx};
		else if (idx == LOC_CS2_IDX)
			s = '{1'b1, 1'b0, 1'b1, idx};
		else if (idx == LOC_STAT_IDX)
			s = '{1'b1, 1'b1, 1'b0, idx};
		return s;
	endfunction : rcp_lookup

	function automatic logic rcp_odd_par(input logic [DATA_W-1:0] d);
		return ~^d;
	endfunction : rcp_odd_par

endpackage : rcp_pkg

// [design/rcp_link_if.sv]
// host bus and drive control bus joining the controller and its far end
`timescale 1ns/1ps
interface rcp_link_if;
	import rcp_pkg::*;
	logic [ADDR_W-1:0] addr;        // host address, processor driven
	logic              c1;          // host control line c1
	logic              c0;          // host control line c0
	logic              msyn;        // master sync
	logic              ssyn;        // slave sync
	logic [DATA_W-1:0] hd_cpu_out;  // host data from processor
	logic              hd_cpu_oe;
	logic [DATA_W-1:0] hd_dev_out;  // host data from controller
	logic              hd_dev_oe;
	logic [DATA_W-1:0] hd;          // resolved host data
	logic [DATA_W-1:0] cd_dev_out;  // control_data_lines from controller
	logic              cp_dev_out;  // control_parity_bit from controller
	logic              cd_dev_oe;
	logic [DATA_W-1:0] cd_drv_out;  // control_data_lines from drive
	logic              cp_drv_out;
	logic              cd_drv_oe;
	logic [DATA_W-1:0] cd;          // resolved control_data_lines
	logic              cp;          // resolved control_parity_bit
	logic [REGISTER_SELECT_CODE_W-1:0] register_select_code;
	logic [UNIT_W-1:0] drive_unit_select;
	logic              controller_to_drive_dir;
	logic              control_demand;
	logic              control_transfer_ack;

	assign hd = hd_dev_oe ? hd_dev_out : (hd_cpu_oe ? hd_cpu_out : '0);
	assign cd = cd_dev_oe ? cd_dev_out : (cd_drv_oe ? cd_drv_out : '0);
	assign cp = cd_dev_oe ? cp_dev_out : (cd_drv_oe ? cp_drv_out : 1'b0);

	modport dev (
		input  addr, c1, c0, msyn, hd, cd, cp, control_transfer_ack,
		output ssyn, hd_dev_out, hd_dev_oe, cd_dev_out, cp_dev_out, cd_dev_oe,
		output register_select_code, drive_unit_select, controller_to_drive_dir,
		output control_demand
	);
	modport far (
		output addr, c1, c0, msyn, hd_cpu_out, hd_cpu_oe,
		output cd_drv_out, cp_drv_out, cd_drv_oe, control_transfer_ack,
		input  ssyn, hd, cd, cp, register_select_code, drive_unit_select,
		input  controller_to_drive_dir, control_demand
	);
endinterface : rcp_link_if

// [design/rcp_sync3.sv]
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module rcp_sync3 #(
	parameter int W = 1
) (
	input  wire logic         clk,    // clock
	input  wire logic         rst_n,  // async reset, active low
	input  wire logic [W-1:0] d,      // asynchronous inputs
	output logic      [W-1:0] q       // filtered synchronous outputs
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q      <= '0;
		end
		else
		begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q      <= (s2_reg & s3_reg) | (q & (s2_reg ^ s3_reg));
		end
	end
endmodule : rcp_sync3

// [design/rcp_device.sv]
// controller end: host slave decode, local registers, drive control bus master
`timescale 1ns/1ps
module rcp_device
	import rcp_pkg::*;
(
	input  wire logic              clk,            // clock, 40 MHz
	input  wire logic              rst_n,          // async reset, active low
	rcp_link_if.dev                bus,            // host bus and control bus
	input  wire logic [JMP_W-1:0]  base_jumper,    // jumper-set address field
	output logic [DATA_W-1:0]      word_count,     // word count register
	output logic                   parity_error    // sticky control parity fault
);
	// ************************************************************
	// synchronised handshake inputs
	// ************************************************************
	logic [1:0] sync_q;
	logic       msyn_s;
	logic       tra_s;

	rcp_sync3 #(.W(2)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({bus.msyn, bus.control_transfer_ack}),
		.q     (sync_q)
	);
	assign msyn_s = sync_q[1];
	assign tra_s  = sync_q[0];

	// ************************************************************
	// address decode
	// ************************************************************
	logic              claim_hit;
	logic [REGISTER_SELECT_CODE_W-1:0] idx;
	rcp_sel_t          sel;
	logic              dir_in;
	logic              hi_byte;
	logic              lo_byte;

	assign claim_hit = BIG_MAP ? (bus.addr[17:6] == base_jumper[12:1])
	                           : (bus.addr[17:5] == base_jumper);
	assign idx = BIG_MAP ? bus.addr[5:1] : {1'b0, bus.addr[4:1]};
	assign sel = rcp_lookup(idx);

	// ************************************************************
	// captured cycle
	// ************************************************************
	rcp_state_t        state_reg;
	logic [CNT_W-1:0]  cnt_reg;
	rcp_sel_t          sel_reg;
	rcp_cyc_t          cyc_reg;
	logic              a0_reg;
	logic [DATA_W-1:0] wdata_reg;
	logic              device_claim_pulse;
	logic              register_load_strobe;
	logic              last;
	logic              start;
	logic              load_now;

	assign last  = (cnt_reg == CNT_W'(1));
	assign start = (state_reg == ST_IDLE) && msyn_s && claim_hit;
	// c1 high is a write; a byte write picks its lane from a0
	assign dir_in  = cyc_reg[1];
	assign hi_byte = dir_in && (cyc_reg == RCP_DATO || a0_reg);
	assign lo_byte = dir_in && (cyc_reg == RCP_DATO || !a0_reg);
	// registers load in the strobe's first cycle, gated by the strobe itself
	assign load_now = register_load_strobe && (cnt_reg == STROBE_LEN_CYC) && msyn_s;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel_reg   <= '0;
			cyc_reg   <= RCP_DATI;
			a0_reg    <= 1'b0;
			wdata_reg <= '0;
		end
		else if (device_claim_pulse)
		begin
			sel_reg   <= sel;
			cyc_reg   <= rcp_cyc_t'({bus.c1, bus.c0});
			a0_reg    <= bus.addr[0];
			wdata_reg <= bus.hd;
		end
	end

	// ************************************************************
	// sequencer
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_IDLE;
			cnt_reg   <= '0;
		end
		else
		begin
			cnt_reg <= (cnt_reg != '0) ? cnt_reg - CNT_W'(1) : cnt_reg;
			unique case (state_reg)
				ST_IDLE:
					if (start)
					begin
						if (sel.local_remote_flag)
						begin
							state_reg <= ST_CLAIM;
							cnt_reg   <= STROBE_DELAY_CYC;
						end
						else
						begin
							state_reg <= ST_SETTLE;
							cnt_reg   <= DEMAND_SETTLE_CYC;
						end
					end
				ST_CLAIM:
					if (!msyn_s)
						state_reg <= ST_IDLE;
					else if (last)
					begin
						state_reg <= ST_STROBE;
						cnt_reg   <= STROBE_LEN_CYC;
					end
				ST_STROBE:
					if (!msyn_s)
						state_reg <= ST_IDLE;
					else if (last)
						state_reg <= ST_SSYN;
				ST_SSYN:
					if (!msyn_s)
						state_reg <= sel_reg.local_remote_flag ? ST_IDLE : ST_RELEASE;
				ST_SETTLE:
					if (!msyn_s)
						state_reg <= ST_RELEASE;
					else if (last)
						state_reg <= ST_DEMAND;
				ST_DEMAND:
					if (!msyn_s)
						state_reg <= ST_RELEASE;
					else if (tra_s && dir_in)
						state_reg <= ST_SSYN;
					else if (tra_s)
					begin
						state_reg <= ST_RDLY;
						cnt_reg   <= READ_SSYN_CYC;
					end
				ST_RDLY:
					if (!msyn_s)
						state_reg <= ST_RELEASE;
					else if (last)
						state_reg <= ST_SSYN;
				ST_RELEASE:
					if (!tra_s)
						state_reg <= ST_IDLE;
			endcase
		end
	end

	assign device_claim_pulse   = start;
	assign register_load_strobe = (state_reg == ST_STROBE);

	// ************************************************************
	// host handshake and read bus
	// ************************************************************
	logic [DATA_W-1:0] internal_read_bus;
	logic [DATA_W-1:0] status_word;
	logic [UNIT_W-1:0] unit_reg;
	logic [7:0]        remote_cnt_reg;

	// clear bit of control_status_two is write-only and always reads zero
	assign status_word = {remote_cnt_reg, 7'h00, parity_error};
	always_comb
	begin
		internal_read_bus = '0;
		if (sel_reg.register_select_code == LOC_WC_IDX)
			internal_read_bus = word_count;
		else if (sel_reg.register_select_code == LOC_CS2_IDX)
			internal_read_bus = {13'h0000, unit_reg};
		else if (sel_reg.register_select_code == LOC_STAT_IDX)
			internal_read_bus = status_word;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bus.ssyn <= 1'b0;
		else if (!msyn_s)
			bus.ssyn <= 1'b0;
		else if ((state_reg == ST_STROBE && last) ||
		         (state_reg == ST_DEMAND && tra_s && dir_in) ||
		         (state_reg == ST_RDLY && last))
			bus.ssyn <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus.hd_dev_out <= '0;
			bus.hd_dev_oe  <= 1'b0;
		end
		else if (!msyn_s)
			bus.hd_dev_oe <= 1'b0;
		else if (load_now && !dir_in)
		begin
			bus.hd_dev_out <= internal_read_bus;
			bus.hd_dev_oe  <= 1'b1;
		end
		else if (state_reg == ST_DEMAND && tra_s && !dir_in)
		begin
			bus.hd_dev_out <= bus.cd;
			bus.hd_dev_oe  <= 1'b1;
		end
	end

	// ************************************************************
	// local registers
	// ************************************************************
	logic cs2_hit;
	assign cs2_hit = load_now && sel_reg.register_select_code == LOC_CS2_IDX;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			word_count <= WC_RST;
		else if (load_now && sel_reg.register_select_code == LOC_WC_IDX)
		begin
			if (hi_byte)
				word_count[15:8] <= wdata_reg[15:8];
			if (lo_byte)
				word_count[7:0] <= wdata_reg[7:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			unit_reg <= UNIT_RST;
		else if (cs2_hit && lo_byte)
			unit_reg <= wdata_reg[CS2_UNIT_LSB +: UNIT_W];
	end

	// a parity fault arriving with the clear still sets the flag
	logic clr_now;
	logic perr_now;
	assign clr_now  = cs2_hit && lo_byte && wdata_reg[CS2_CLR_BIT];
	assign perr_now = state_reg == ST_DEMAND && tra_s && !dir_in &&
	                  (bus.cp != rcp_odd_par(bus.cd));

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			parity_error   <= 1'b0;
			remote_cnt_reg <= 8'h00;
		end
		else
		begin
			if (perr_now)
				parity_error <= 1'b1;
			else if (clr_now)
				parity_error <= 1'b0;
			if (state_reg == ST_DEMAND && tra_s)
				remote_cnt_reg <= remote_cnt_reg + 8'h01;
			else if (clr_now)
				remote_cnt_reg <= 8'h00;
		end
	end

	// ************************************************************
	// drive control bus
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bus.control_demand <= 1'b0;
		else if (!msyn_s)
			bus.control_demand <= 1'b0;
		else if (state_reg == ST_SETTLE && last)
			bus.control_demand <= 1'b1;
	end

	// select lines stay at zero unless a remote cycle owns the bus
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus.register_select_code    <= '0;
			bus.drive_unit_select       <= '0;
			bus.controller_to_drive_dir <= 1'b0;
			bus.cd_dev_out              <= '0;
			bus.cp_dev_out              <= 1'b0;
			bus.cd_dev_oe               <= 1'b0;
		end
		else if (start && !sel.local_remote_flag)
		begin
			bus.register_select_code    <= sel.register_select_code;
			bus.drive_unit_select       <= unit_reg;
			bus.controller_to_drive_dir <= bus.c1;
			bus.cd_dev_out              <= bus.hd;
			bus.cp_dev_out              <= rcp_odd_par(bus.hd);
			bus.cd_dev_oe               <= bus.c1;
		end
		else if (state_reg == ST_IDLE)
		begin
			bus.register_select_code    <= '0;
			bus.drive_unit_select       <= '0;
			bus.controller_to_drive_dir <= 1'b0;
			bus.cd_dev_oe               <= 1'b0;
		end
	end
endmodule : rcp_device

// [design/rcp_far_end.sv]
// far end: host processor master and one drive on the control bus
`timescale 1ns/1ps
module rcp_far_end
	import rcp_pkg::*;
(
	input  wire logic              clk,        // clock, 40 MHz
	input  wire logic              rst_n,      // async reset, active low
	rcp_link_if.far                bus,        // host bus and control bus
	input  wire logic              req,        // start a host cycle, pulse
	input  wire logic [ADDR_W-1:0] req_addr,   // host address
	input  wire logic [1:0]        req_cyc,    // {c1,c0} cycle code
	input  wire logic [DATA_W-1:0] req_wdata,  // write data
	output logic                   done,       // cycle finished, pulse
	output logic [DATA_W-1:0]      rdata,      // read data of last cycle
	input  wire logic [UNIT_W-1:0] my_unit,    // this drive's unit number
	input  wire logic [DATA_W-1:0] drv_rdata,  // drive register to return
	output logic                   drv_wr,     // drive register load, pulse
	output logic [REGISTER_SELECT_CODE_W-1:0]      drv_reg,    // addressed drive register
	output logic [DATA_W-1:0]      drv_wdata,  // data loaded into drive
	output logic                   drv_perr    // parity fault on load, pulse
);
	logic [1:0] sync_q;
	logic       ssyn_s;
	logic       dem_s;

	rcp_sync3 #(.W(2)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({bus.ssyn, bus.control_demand}),
		.q     (sync_q)
	);
	assign ssyn_s = sync_q[1];
	assign dem_s  = sync_q[0];

	// ************************************************************
	// processor
	// ************************************************************
	// gray order along idle, setup, wait for ssyn, hold
	typedef enum logic [1:0] {
		P_IDLE  = 2'h0,
		P_SETUP = 2'h1,
		P_WAIT  = 2'h3,
		P_HOLD  = 2'h2
	} rcp_cpu_state_t;
	rcp_cpu_state_t   p_state_reg;
	logic [CNT_W-1:0] p_cnt_reg;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			p_state_reg    <= P_IDLE;
			p_cnt_reg      <= '0;
			bus.addr       <= '0;
			bus.c1         <= 1'b0;
			bus.c0         <= 1'b0;
			bus.msyn       <= 1'b0;
			bus.hd_cpu_out <= '0;
			bus.hd_cpu_oe  <= 1'b0;
			done           <= 1'b0;
			rdata          <= '0;
		end
		else
		begin
			done <= 1'b0;
			unique case (p_state_reg)
				P_IDLE:
					if (req)
					begin
						bus.addr       <= req_addr;
						{bus.c1, bus.c0} <= req_cyc;
						bus.hd_cpu_out <= req_wdata;
						bus.hd_cpu_oe  <= req_cyc[1];
						p_cnt_reg      <= MSYN_SETUP_CYC;
						p_state_reg    <= P_SETUP;
					end
				P_SETUP:
					if (p_cnt_reg == CNT_W'(1))
					begin
						bus.msyn    <= 1'b1;
						p_state_reg <= P_WAIT;
					end
					else
						p_cnt_reg <= p_cnt_reg - CNT_W'(1);
				P_WAIT:
					if (ssyn_s)
					begin
						rdata       <= bus.hd;
						bus.msyn    <= 1'b0;
						p_cnt_reg   <= ADDR_HOLD_CYC;
						p_state_reg <= P_HOLD;
					end
				P_HOLD:
					if (p_cnt_reg != CNT_W'(0))
						p_cnt_reg <= p_cnt_reg - CNT_W'(1);
					else if (!ssyn_s)
					begin
						bus.hd_cpu_oe <= 1'b0;
						done          <= 1'b1;
						p_state_reg   <= P_IDLE;
					end
			endcase
		end
	end

	// ************************************************************
	// drive
	// ************************************************************
	logic hit;
	assign hit = dem_s && bus.drive_unit_select == my_unit;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus.control_transfer_ack <= 1'b0;
			bus.cd_drv_out           <= '0;
			bus.cp_drv_out           <= 1'b0;
			bus.cd_drv_oe            <= 1'b0;
			drv_wr                   <= 1'b0;
			drv_reg                  <= '0;
			drv_wdata                <= '0;
			drv_perr                 <= 1'b0;
		end
		else
		begin
			drv_wr   <= 1'b0;
			drv_perr <= 1'b0;
			drv_reg  <= bus.register_select_code;
			if (!dem_s)
			begin
				bus.control_transfer_ack <= 1'b0;
				bus.cd_drv_oe            <= 1'b0;
			end
			else if (hit && !bus.control_transfer_ack)
			begin
				bus.control_transfer_ack <= 1'b1;
				if (bus.controller_to_drive_dir)
				begin
					drv_wr    <= 1'b1;
					drv_wdata <= bus.cd;
					drv_perr  <= bus.cp != rcp_odd_par(bus.cd);
				end
				else
				begin
					bus.cd_drv_out <= drv_rdata;
					bus.cp_drv_out <= rcp_odd_par(drv_rdata);
					bus.cd_drv_oe  <= 1'b1;
				end
			end
		end
	end
endmodule : rcp_far_end

// [verif/rcp_monitor.sv]
// assertions on the link between controller and far end
`timescale 1ns/1ps
module rcp_monitor
	import rcp_pkg::*;
#(
	parameter logic [JMP_W-1:0] BASE = 13'h0000 // controller jumper field
) (
	input wire logic              clk,                     // clock
	input wire logic              rst_n,                   // reset, active low
	input wire logic [ADDR_W-1:0] addr,                    // host address
	input wire logic              c1,                      // host control c1
	input wire logic              msyn,                    // master sync
	input wire logic              ssyn,                    // slave sync
	input wire logic [DATA_W-1:0] cd,                      // control data
	input wire logic              cp,                      // control parity
	input wire logic              cd_dev_oe,               // controller drives cd
	input wire logic              cd_drv_oe,               // drive drives cd
	input wire logic              controller_to_drive_dir, // direction
	input wire logic              control_demand,          // demand
	input wire logic              control_transfer_ack     // transfer ack
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	logic ours;
	logic loc;
	assign ours = addr[17:5] == BASE;
	assign loc  = ours && addr[4:1] < 4'h3;
	// windows allow for the three-flop msyn synchroniser
	a_ignore_foreign: assert property ($rose(msyn) && !ours |-> !ssyn[*8])
		else $error("ssyn on foreign address");
	a_local_ssyn_time: assert property (
		$rose(msyn) && loc |-> !ssyn[*8] ##[3:9] ssyn) else $error("local ssyn timing");
	a_ssyn_release: assert property ($fell(msyn) |-> ##[1:6] !ssyn)
		else $error("ssyn held");
	a_demand_settle: assert property (
		$rose(control_demand) |-> $past(msyn, 11) && !$past(msyn, 16)) else $error("early demand");
	a_write_ack_ssyn: assert property (
		$rose(control_transfer_ack) && controller_to_drive_dir |-> ##[2:6] ssyn)
		else $error("write ssyn late");
	a_read_ssyn_delay: assert property (
		$rose(control_transfer_ack) && !controller_to_drive_dir |-> !ssyn[*8] ##[3:7] ssyn)
		else $error("read ssyn timing");
	a_demand_drop: assert property ($fell(msyn) |-> ##[1:6] !control_demand)
		else $error("demand held");
	a_dir_follows: assert property (
		control_demand |-> controller_to_drive_dir == c1) else $error("wrong direction");
	a_parity_odd: assert property (cd_dev_oe || cd_drv_oe |-> ^{cp, cd})
		else $error("control parity even");
	a_msyn_setup: assert property ($rose(msyn) |-> $past(addr, 6) == addr)
		else $error("msyn before address settled");
	a_addr_hold: assert property ($fell(msyn) |-> $stable(addr)[*4])
		else $error("address moved after msyn");
	a_local_quiet: assert property (
		$rose(msyn) && loc |-> (!control_demand && !cd_dev_oe)[*8])
		else $error("control bus busy on local access");
endmodule : rcp_monitor

// [verif/register_control_path_bench.sv]
// self-checking bench joining controller and far end
`timescale 1ns/1ps
module register_control_path_bench;
	import rcp_pkg::*;
	localparam logic [JMP_W-1:0] JMP = 13'h0A5A;
	logic              clk;
	logic              rst_n;
	logic              req;
	logic [ADDR_W-1:0] req_addr;
	logic [1:0]        req_cyc;
	logic [DATA_W-1:0] req_wdata;
	logic              done;
	logic [DATA_W-1:0] rdata;
	logic [UNIT_W-1:0] my_unit;
	logic [DATA_W-1:0] drv_rdata;
	logic [REGISTER_SELECT_CODE_W-1:0] drv_reg;
	logic [DATA_W-1:0] drv_wdata;
	logic [DATA_W-1:0] word_count;
	logic              parity_error;
	logic              drv_wr;
	logic              drv_perr;
	int                wr_count = 0;
	int                perr_count = 0;
	int                err_total;
	int                num_checks;
	rcp_link_if bus ();
	rcp_device i_rcp_device (.clk(clk), .rst_n(rst_n), .bus(bus), .base_jumper(JMP),
		.word_count(word_count), .parity_error(parity_error));
	rcp_far_end i_rcp_far_end (.clk(clk), .rst_n(rst_n), .bus(bus), .req(req),
		.req_addr(req_addr), .req_cyc(req_cyc), .req_wdata(req_wdata), .done(done),
		.rdata(rdata), .my_unit(my_unit), .drv_rdata(drv_rdata), .drv_wr(drv_wr),
		.drv_reg(drv_reg), .drv_wdata(drv_wdata), .drv_perr(drv_perr));
	rcp_monitor #(.BASE(JMP)) i_rcp_monitor (.clk(clk), .rst_n(rst_n), .addr(bus.addr),
		.c1(bus.c1), .msyn(bus.msyn), .ssyn(bus.ssyn), .cd(bus.cd), .cp(bus.cp),
		.cd_dev_oe(bus.cd_dev_oe), .cd_drv_oe(bus.cd_drv_oe),
		.controller_to_drive_dir(bus.controller_to_drive_dir),
		.control_demand(bus.control_demand), .control_transfer_ack(bus.control_transfer_ack));
	// drive pulses stand one cycle only, so they are counted as they pass
	always @(posedge clk)
	begin
		wr_count   <= wr_count + int'(drv_wr);
		perr_count <= perr_count + int'(drv_perr);
	end
	// ********************************
	// tasks
	// ********************************
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic host(input logic [3:0] idx, input logic a0, input logic [1:0] cyc,
		input logic [15:0] w);
		@(negedge clk);
		req       = 1'b1;
		req_addr  = {JMP, idx, a0};
		req_cyc   = cyc;
		req_wdata = w;
		@(negedge clk);
		req = 1'b0;
		while (done !== 1'b1)
			@(negedge clk);
	endtask : host
	task automatic close_out;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out
	task automatic test_local;
		host(4'h0, 1'b0, RCP_DATO, 16'h1234);
		chk("word count", word_count, 16'h1234);
		host(4'h0, 1'b1, RCP_DATOB, 16'hAB00);
		host(4'h0, 1'b0, RCP_DATOB, 16'h00CD);
		host(4'h0, 1'b0, RCP_DATI, 16'h0000);
		chk("byte lanes", rdata, 16'hABCD);
		$display("test local done");
	endtask : test_local
	task automatic test_cs2;
		host(4'h1, 1'b0, RCP_DATO, 16'h0025);
		host(4'h1, 1'b0, RCP_DATIP, 16'h0000);
		chk("clear bit", rdata, 16'h0005);
		host(4'h2, 1'b0, RCP_DATO, 16'hFFFF);
		host(4'h2, 1'b0, RCP_DATI, 16'h0000);
		chk("status", rdata, 16'h0000);
		$display("test cs2 done");
	endtask : test_cs2
	task automatic test_remote;
		host(4'h5, 1'b0, RCP_DATO, 16'h5AA5);
		chk("drive data", drv_wdata, 16'h5AA5);
		chk("drive reg", {11'h000, drv_reg}, 16'h0005);
		chk("drive loads", 16'(wr_count), 16'h0001);
		host(4'h6, 1'b0, RCP_DATI, 16'h0000);
		chk("remote read", rdata, 16'hC3F0);
		chk("load parity", 16'(perr_count), 16'h0000);
		chk("read parity", {15'h0000, parity_error}, 16'h0000);
		host(4'h2, 1'b0, RCP_DATI, 16'h0000);
		chk("remote count", rdata, 16'h0200);
		$display("test remote done");
	endtask : test_remote
	task automatic test_foreign;
		@(negedge clk);
		req      = 1'b1;
		req_addr = {~JMP, 5'h00};
		req_cyc  = RCP_DATO;
		@(negedge clk);
		req = 1'b0;
		repeat (40) @(negedge clk);
		chk("foreign write", word_count, 16'hABCD);
		chk("foreign ssyn", {15'h0000, bus.ssyn}, 16'h0000);
		// the far end waits for ssyn forever, so only reset frees it
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		chk("reset count", word_count, WC_RST);
		$display("test foreign done");
	endtask : test_foreign
	// ********************************
	// scenarios
	// ********************************
	initial
	begin
		clk = 1'b0;
		forever
			#12.5 clk = ~clk;
	end
	initial
	begin
		rst_n = 1'b0;
		req = 1'b0;
		req_addr = '0;
		req_cyc = 2'h0;
		req_wdata = '0;
		my_unit = 3'h5;
		drv_rdata = 16'hC3F0;
		err_total = 0;
		num_checks = 0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		test_local;
		test_cs2;
		test_remote;
		test_foreign;
		close_out;
	end
	initial
	begin
		// a dozen host cycles need about 600 clocks
		repeat (4000) @(posedge clk);
		err_total++;
		close_out;
	end
endmodule : register_control_path_bench
